// *** hw/bsm_params.svh ***
`ifndef BSM_PARAMS_SVH
`define BSM_PARAMS_SVH

// ==========================================================================
// register indices (byte address is four times the index)
`define BSM_IDX_MODE        4'h0
`define BSM_IDX_THR         4'h1
`define BSM_IDX_WLVL        4'h8
`define BSM_IDX_WIRQ        4'h9
`define BSM_IDX_WFLG        4'ha
`define BSM_IDX_WSTS        4'hb

// ==========================================================================
// field positions
`define BSM_SRATE_BIT       4
`define BSM_ACT_HI          3
`define BSM_ACT_LO          2
`define BSM_SLP_HI          1
`define BSM_SLP_LO          0
`define BSM_THR_HI          2
`define BSM_THR_LO          0
`define BSM_WLVL_HI         1
`define BSM_WLVL_LO         0
`define BSM_EDGE_HI         2
`define BSM_EDGE_LO         1
`define BSM_IE_BIT          0
`define BSM_IF_BIT          0
`define BSM_LS_BIT          0

// fuse byte layout
`define BSM_FUSE_THR_HI     7
`define BSM_FUSE_THR_LO     5

// ==========================================================================
// reset values
`define BSM_RST_WLVL        8'h00
`define BSM_RST_WIRQ        8'h00
`define BSM_RST_WFLG        8'h00
`define BSM_RST_WSTS        8'h00

// ==========================================================================
// timing
`define BSM_CLK_HZ          10000000
`define BSM_FAST_HZ         1000
`define BSM_SLOW_HZ         125

`endif

// *** hw/bsm_pkg.sv ***
`default_nettype none

package bsm_pkg;

    // ======================================================================
    // operating mode codes
    typedef enum logic [1:0] {
        BSM_MODE_OFF   = 2'h0,
        BSM_MODE_ON    = 2'h1,
        BSM_MODE_SMP   = 2'h2,
        BSM_MODE_HOLD  = 2'h3
    } bsm_mode_e;

    // warning edge select codes
    typedef enum logic [1:0] {
        BSM_EDGE_FALL  = 2'h0,
        BSM_EDGE_RISE  = 2'h1,
        BSM_EDGE_BOTH  = 2'h2,
        BSM_EDGE_RSVD  = 2'h3
    } bsm_edge_e;

    // monitor states, one-hot
    typedef enum logic [2:0] {
        BSM_ST_OFF     = 3'b001,
        BSM_ST_CONT    = 3'b010,
        BSM_ST_SAMP    = 3'b100
    } bsm_state_e;

endpackage : bsm_pkg

`default_nettype wire

// *** hw/bsm_sampler.sv ***
`include "bsm_params.svh"
`default_nettype none

module bsm_sampler
    import bsm_pkg::*;
#(
    parameter int FAST_CYC = `BSM_CLK_HZ / `BSM_FAST_HZ,
    parameter int SLOW_CYC = `BSM_CLK_HZ / `BSM_SLOW_HZ
) (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic run,
    input  wire logic slow,
    output logic      tick
);

    // ======================================================================
    // period counter
    logic [16:0] cnt_reg;
    logic [16:0] limit;

    // period picks 1 kHz or 125 Hz
    assign limit = slow ? 17'(SLOW_CYC - 1) : 17'(FAST_CYC - 1);

    // count while sampling, restart when stopped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_reg <= 17'h00000;
        end else if (!run || cnt_reg >= limit) begin
            cnt_reg <= 17'h00000;
        end else begin
            cnt_reg <= cnt_reg + 17'h00001;
        end
    end

    assign tick = run && (cnt_reg == limit);

    chk_tick_spacing: assert property (@(posedge hclk) disable iff (!hresetn)
        (tick && !slow) |-> (cnt_reg == 17'(FAST_CYC - 1))) else $error("sample tick off period");

endmodule : bsm_sampler

`default_nettype wire

// *** hw/bsm_regs.sv ***
`include "bsm_params.svh"
`default_nettype none

module bsm_regs
    import bsm_pkg::*;
#(
    parameter int FAST_CYC = `BSM_CLK_HZ / `BSM_FAST_HZ,
    parameter int SLOW_CYC = `BSM_CLK_HZ / `BSM_SLOW_HZ
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [7:0]  monitor_config_fuse,
    input  wire logic        change_protection_unlock,
    input  wire logic        deep_sleep,
    input  wire logic        supply_below_warning,
    output logic             monitor_enable,
    output logic             wake_halt,
    output logic [12:0]      warning_threshold_mv,
    output logic [12:0]      reset_threshold_mv,
    output logic             warning_irq
);

    // ======================================================================
    // decode helpers
    function automatic logic [12:0] thr_mv(input logic [2:0] code);
        case (code)
            3'h0:    thr_mv = 13'd1800;
            3'h1:    thr_mv = 13'd2150;
            3'h2:    thr_mv = 13'd2600;
            3'h3:    thr_mv = 13'd2950;
            3'h4:    thr_mv = 13'd3300;
            3'h5:    thr_mv = 13'd3700;
            3'h6:    thr_mv = 13'd4000;
            default: thr_mv = 13'd4300;
        endcase
    endfunction : thr_mv

    function automatic logic [6:0] offset_pct(input logic [1:0] code);
        case (code)
            2'h0:    offset_pct = 7'd105;
            2'h1:    offset_pct = 7'd115;
            default: offset_pct = 7'd125;  // reserved codes treated as widest
        endcase
    endfunction : offset_pct

    function automatic logic idx_hit(input logic [3:0] idx, input logic [3:0] want);
        idx_hit = (idx == want);
    endfunction : idx_hit

    // ======================================================================
    // register state
    logic              fuse_done_reg;
    logic              srate_reg;
    logic [1:0]        act_mode_reg;
    logic [1:0]        slp_mode_reg;
    logic [2:0]        thr_code_reg;
    logic [1:0]        wlvl_reg;
    logic [1:0]        edge_reg;
    logic              ie_reg;
    logic              flag_reg;
    logic              live_reg;
    logic              ready_reg;
    logic              wr_pend_reg;
    logic [3:0]        wr_idx_reg;
    logic [31:0]       rdata_reg;
    logic [12:0]       warn_mv_reg;
    logic [12:0]       rst_mv_reg;
    logic              sync1_reg;
    logic              sync2_reg;
    bsm_state_e        state_reg;
    bsm_state_e        state_next;

    logic              addr_ok;
    logic [3:0]        a_idx;
    logic              wr_mode;
    logic              wr_wlvl;
    logic              wr_wirq;
    logic              wr_wflg;
    logic              tick;
    logic              upd;
    logic              trig;
    logic [1:0]        cur_mode;
    logic [19:0]       warn_prod;

    // ======================================================================
    // ahb-lite slave front end, zero wait states
    assign a_idx     = haddr[5:2];
    assign addr_ok   = hsel && htrans[1] && hready;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_reg;

    // address phase capture for writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg  <= 4'h0;
        end else begin
            wr_pend_reg <= addr_ok && hwrite && (haddr[7:6] == 2'b00) && (haddr[1:0] == 2'b00);
            wr_idx_reg  <= a_idx;
        end
    end

    assign wr_mode = wr_pend_reg && idx_hit(wr_idx_reg, `BSM_IDX_MODE);
    assign wr_wlvl = wr_pend_reg && idx_hit(wr_idx_reg, `BSM_IDX_WLVL);
    assign wr_wirq = wr_pend_reg && idx_hit(wr_idx_reg, `BSM_IDX_WIRQ);
    assign wr_wflg = wr_pend_reg && idx_hit(wr_idx_reg, `BSM_IDX_WFLG);

    // read data registered at the address phase, unmapped reads zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_reg <= 32'h00000000;
        end else if (addr_ok && !hwrite) begin
            rdata_reg <= 32'h00000000;
            if (haddr[7:6] == 2'b00) begin
                case (a_idx)
                    `BSM_IDX_MODE: rdata_reg[4:0] <= {srate_reg, act_mode_reg, slp_mode_reg};
                    `BSM_IDX_THR:  rdata_reg[2:0] <= thr_code_reg;
                    `BSM_IDX_WLVL: rdata_reg[1:0] <= wlvl_reg;
                    `BSM_IDX_WIRQ: rdata_reg[2:0] <= {edge_reg, ie_reg};
                    `BSM_IDX_WFLG: rdata_reg[0]   <= flag_reg;
                    `BSM_IDX_WSTS: rdata_reg[0]   <= live_reg;
                    default:       rdata_reg      <= 32'h00000000;
                endcase
            end
        end
    end

    // ======================================================================
    // fuse load right after reset release
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fuse_done_reg <= 1'b0;
        end else begin
            fuse_done_reg <= 1'b1;
        end
    end

    // active mode and threshold: fuse only, bus writes ignored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            act_mode_reg <= 2'h0;
            thr_code_reg <= 3'h0;
        end else if (!fuse_done_reg) begin
            act_mode_reg <= monitor_config_fuse[`BSM_ACT_HI:`BSM_ACT_LO];
            thr_code_reg <= monitor_config_fuse[`BSM_FUSE_THR_HI:`BSM_FUSE_THR_LO];
        end
    end

    // protected fields: fuse at reset, then only with unlock open
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            srate_reg    <= 1'b0;
            slp_mode_reg <= 2'h0;
        end else if (!fuse_done_reg) begin
            srate_reg    <= monitor_config_fuse[`BSM_SRATE_BIT];
            slp_mode_reg <= monitor_config_fuse[`BSM_SLP_HI:`BSM_SLP_LO];
        end else if (wr_mode && change_protection_unlock) begin
            srate_reg    <= hwdata[`BSM_SRATE_BIT];
            slp_mode_reg <= hwdata[`BSM_SLP_HI:`BSM_SLP_LO];
        end
    end

    // warning level and interrupt control
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wlvl_reg <= 2'(`BSM_RST_WLVL);
            edge_reg <= 2'h0;
            ie_reg   <= 1'b0;
        end else begin
            if (wr_wlvl) begin
                wlvl_reg <= hwdata[`BSM_WLVL_HI:`BSM_WLVL_LO];
            end
            if (wr_wirq) begin
                edge_reg <= hwdata[`BSM_EDGE_HI:`BSM_EDGE_LO];
                ie_reg   <= hwdata[`BSM_IE_BIT];
            end
        end
    end

    // ======================================================================
    // threshold outputs
    assign warn_prod = 20'(thr_mv(thr_code_reg)) * 20'(offset_pct(wlvl_reg));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rst_mv_reg  <= 13'h0000;
            warn_mv_reg <= 13'h0000;
        end else begin
            rst_mv_reg  <= thr_mv(thr_code_reg);
            warn_mv_reg <= 13'(warn_prod / 20'd100);
        end
    end

    assign reset_threshold_mv   = rst_mv_reg;
    assign warning_threshold_mv = warn_mv_reg;

    // ======================================================================
    // monitor state follows sleep or active mode
    assign cur_mode = deep_sleep ? slp_mode_reg : act_mode_reg;

    always_comb begin
        case (cur_mode)
            BSM_MODE_ON:   state_next = BSM_ST_CONT;
            BSM_MODE_HOLD: state_next = deep_sleep ? BSM_ST_OFF : BSM_ST_CONT;
            BSM_MODE_SMP:  state_next = BSM_ST_SAMP;
            default:       state_next = BSM_ST_OFF;
        endcase
        if (!fuse_done_reg) begin
            state_next = BSM_ST_OFF;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= BSM_ST_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    bsm_sampler #(
        .FAST_CYC (FAST_CYC),
        .SLOW_CYC (SLOW_CYC)
    ) u_sampler (
        .hclk    (hclk),
        .hresetn (hresetn),
        .run     (state_reg == BSM_ST_SAMP),
        .slow    (srate_reg),
        .tick    (tick)
    );

    // comparator pin synchroniser
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else begin
            sync1_reg <= supply_below_warning;
            sync2_reg <= sync1_reg;
        end
    end

    assign upd = (state_reg == BSM_ST_CONT) || ((state_reg == BSM_ST_SAMP) && tick);
    assign monitor_enable = (state_reg != BSM_ST_OFF);

    // crossing detection against the held level
    always_comb begin
        case (edge_reg)
            BSM_EDGE_FALL: trig = upd && sync2_reg && !live_reg;
            BSM_EDGE_RISE: trig = upd && !sync2_reg && live_reg;
            BSM_EDGE_BOTH: trig = upd && (sync2_reg != live_reg);
            default:       trig = 1'b0;
        endcase
    end

    // live level, held while monitor is off
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            live_reg  <= 1'b0;
            ready_reg <= 1'b0;
        end else begin
            if (upd) begin
                live_reg <= sync2_reg;
            end
            ready_reg <= (state_reg == BSM_ST_OFF) ? 1'b0 : (ready_reg || upd);
        end
    end

    assign wake_halt = (act_mode_reg == BSM_MODE_HOLD) && !ready_reg && fuse_done_reg;

    // sticky flag, set wins over clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_reg <= 1'b0;
        end else if (trig) begin
            flag_reg <= 1'b1;
        end else if (wr_wflg && hwdata[`BSM_IF_BIT]) begin
            flag_reg <= 1'b0;
        end
    end

    assign warning_irq = flag_reg && ie_reg;

    // ======================================================================
    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_clear_write;
        wr_wflg && hwdata[0] && !trig;
    endsequence

    sequence s_locked_write;
        wr_mode && !change_protection_unlock && fuse_done_reg;
    endsequence

    chk_irq_gate: assert property (warning_irq == (flag_reg && ie_reg)) else $error("irq not flag and enable");
    chk_flag_w1c: assert property (s_clear_write |=> !flag_reg) else $error("flag not cleared by one");
    chk_flag_hold: assert property (flag_reg && !(wr_wflg && hwdata[0]) |=> flag_reg)
        else $error("flag dropped on its own");
    chk_trig_sets: assert property (trig |=> flag_reg) else $error("crossing did not set flag");
    chk_fall_edge: assert property ((edge_reg == 2'h0) && upd && sync2_reg && !live_reg |=> flag_reg)
        else $error("falling crossing missed");
    chk_off_quiet: assert property ((state_reg == BSM_ST_OFF) |-> !trig) else $error("flag updated while off");
    chk_active_ro: assert property (fuse_done_reg |=> $stable(act_mode_reg) && $stable(thr_code_reg))
        else $error("fuse field changed");
    chk_sleep_lock: assert property (s_locked_write |=> $stable(slp_mode_reg) && $stable(srate_reg))
        else $error("protected field changed while locked");
    chk_sleep_switch: assert property (deep_sleep && fuse_done_reg && (slp_mode_reg == 2'h0) |=> !monitor_enable)
        else $error("sleep mode not applied");
    chk_irq_holds: assert property (warning_irq && !(wr_wflg && hwdata[0]) && !wr_wirq |=> warning_irq)
        else $error("irq dropped with flag set");
    chk_live_held: assert property (!upd |=> $stable(live_reg)) else $error("live state moved without update");
    chk_rsvd_edge: assert property ((edge_reg == 2'h3) |-> !trig) else $error("reserved edge code triggered");

endmodule : bsm_regs

`default_nettype wire

// *** dv/tb_brownout_supply_monitor_regs.sv ***
`include "bsm_params.svh"
`default_nettype none

module tb_brownout_supply_monitor_regs;
    import bsm_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    // ======================================================================
    // signals
    logic        hclk, hresetn, hsel, hwrite, unlock, deep_sleep, below;
    logic [7:0]  haddr, fuse;
    logic [1:0]  htrans;
    logic [31:0] hwdata, hrdata, rd;
    logic        hreadyout, hresp, mon_en, wake_halt, warning_irq;
    logic [12:0] warn_mv, rst_mv;
    int          err_count, n_checks;

    bsm_regs #(.FAST_CYC(20), .SLOW_CYC(160)) bsm_regs_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .monitor_config_fuse(fuse),
        .change_protection_unlock(unlock), .deep_sleep(deep_sleep), .supply_below_warning(below),
        .monitor_enable(mon_en), .wake_halt(wake_halt), .warning_threshold_mv(warn_mv),
        .reset_threshold_mv(rst_mv), .warning_irq(warning_irq)
    );

    // clock, 100 ns period
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    // ======================================================================
    // checking and closing
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic results;
        $display("checks=%0d errors=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results

    // bounded wait for hready at a rising edge
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            err_count++;
            results();
        end
    endtask : wait_rdy

    // one ahb-lite single transfer, byte address = 4 * index
    task automatic bus(input logic w, input logic [3:0] idx, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= {2'b00, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask : bus

    task automatic rchk(input logic [3:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0000_0000);
        chk(rd, exp);
    endtask : rchk

    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask : cyc

    // compare a settled output; callers step to the falling edge before calling
    task automatic ochk(input logic [31:0] got, input logic [31:0] exp);
        chk(got, exp);
    endtask : ochk

    task automatic do_reset(input logic [7:0] f);
        fuse    <= f;
        hresetn <= 1'b0;
        cyc(2);
        hresetn <= 1'b1;
        cyc(2);
    endtask : do_reset

    // ======================================================================
    // scenarios
    task automatic t_fuse_regs;
        do_reset(8'hb5);
        rchk(`BSM_IDX_MODE, 32'h0000_0015);
        rchk(`BSM_IDX_THR, 32'h0000_0005);
        rchk(`BSM_IDX_WLVL, 32'h0);
        rchk(`BSM_IDX_WIRQ, 32'h0);
        rchk(`BSM_IDX_WFLG, 32'h0);
        rchk(`BSM_IDX_WSTS, 32'h0);
        rchk(4'h2, 32'h0);
        bus(1'b1, 4'h2, 32'hffff_ffff);
        rchk(4'h2, 32'h0);
        bus(1'b1, `BSM_IDX_MODE, 32'h0000_000a);
        rchk(`BSM_IDX_MODE, 32'h0000_0015);
        bus(1'b1, `BSM_IDX_THR, 32'h0000_0007);
        rchk(`BSM_IDX_THR, 32'h0000_0005);
        deep_sleep <= 1'b1;
        @(negedge hclk);
        ochk(mon_en, 1'b1);
        @(posedge hclk);
        unlock <= 1'b1;
        bus(1'b1, `BSM_IDX_MODE, 32'h0000_00f8);
        unlock <= 1'b0;
        rchk(`BSM_IDX_MODE, 32'h0000_0014);
        @(negedge hclk);
        ochk(mon_en, 1'b0);
        @(posedge hclk);
        deep_sleep <= 1'b0;
        cyc(2);
        @(negedge hclk);
        ochk(mon_en, 1'b1);
        @(posedge hclk);
        do_reset(8'hb5);
        rchk(`BSM_IDX_MODE, 32'h0000_0015);
    endtask : t_fuse_regs

    task automatic t_thresholds;
        int mv [8] = '{1800, 2150, 2600, 2950, 3300, 3700, 4000, 4300};
        int pc [4] = '{105, 115, 125, 125};
        for (int c = 0; c < 8; c++) begin
            do_reset({c[2:0], 5'h04});
            for (int l = 0; l < 4; l++) begin
                bus(1'b1, `BSM_IDX_WLVL, 32'(l));
                rchk(`BSM_IDX_WLVL, 32'(l));
                cyc(2);
                @(negedge hclk);
                ochk(32'(rst_mv), 32'(mv[c]));
                ochk(32'(warn_mv), 32'(mv[c] * pc[l] / 100));
                @(posedge hclk);
            end
        end
    endtask : t_thresholds

    // one supply swing, flag and interrupt judged afterwards
    task automatic swing(input logic lvl, input logic fl, input logic ie);
        below <= lvl;
        cyc(6);
        rchk(`BSM_IDX_WFLG, 32'(fl));
        rchk(`BSM_IDX_WSTS, 32'(lvl));
        @(negedge hclk);
        ochk(warning_irq, fl & ie);
        @(posedge hclk);
    endtask : swing

    task automatic t_edges;
        do_reset(8'h04);
        for (int e = 0; e < 4; e++) begin
            bus(1'b1, `BSM_IDX_WIRQ, 32'({e[1:0], 1'b1}));
            rchk(`BSM_IDX_WIRQ, 32'({e[1:0], 1'b1}));
            swing(1'b1, (e == 0 || e == 2), 1'b1);
            bus(1'b1, `BSM_IDX_WFLG, 32'h1);
            rchk(`BSM_IDX_WFLG, 32'h0);
            @(negedge hclk);
            ochk(warning_irq, 1'b0);
            @(posedge hclk);
            swing(1'b0, (e == 1 || e == 2), 1'b1);
            bus(1'b1, `BSM_IDX_WFLG, 32'h1);
        end
        bus(1'b1, `BSM_IDX_WIRQ, 32'h0000_0004);
        swing(1'b1, 1'b1, 1'b0);
        bus(1'b1, `BSM_IDX_WFLG, 32'h0);
        rchk(`BSM_IDX_WFLG, 32'h1);
        bus(1'b1, `BSM_IDX_WIRQ, 32'h0000_0005);
        @(negedge hclk);
        ochk(warning_irq, 1'b1);
        @(posedge hclk);
        below <= 1'b0;
    endtask : t_edges

    task automatic t_modes;
        do_reset(8'h00);
        @(negedge hclk);
        ochk(mon_en, 1'b0);
        @(posedge hclk);
        bus(1'b1, `BSM_IDX_WIRQ, 32'h0000_0005);
        below <= 1'b1;
        cyc(6);
        rchk(`BSM_IDX_WFLG, 32'h0);
        rchk(`BSM_IDX_WSTS, 32'h0);
        @(negedge hclk);
        ochk(warning_irq, 1'b0);
        @(posedge hclk);
        below <= 1'b0;
        // sampled mode, fast then slow rate: live follows only at the tick
        for (int s = 0; s < 2; s++) begin
            do_reset({3'h0, s[0], 4'h8});
            @(negedge hclk);
            ochk(mon_en, 1'b1);
            @(posedge hclk);
            below <= 1'b1;
            cyc((s == 0) ? 14 : 30);
            rchk(`BSM_IDX_WSTS, 32'h0);
            cyc((s == 0) ? 4 : 140);
            rchk(`BSM_IDX_WSTS, 32'h1);
            below <= 1'b0;
        end
        do_reset(8'h0c);
        @(negedge hclk);
        ochk({mon_en, wake_halt}, 2'b11);
        @(posedge hclk);
        cyc(4);
        @(negedge hclk);
        ochk({mon_en, wake_halt}, 2'b10);
        @(posedge hclk);
    endtask : t_modes

    // ======================================================================
    // main sequence
    initial begin
        err_count  = 0;
        n_checks   = 0;
        hresetn    = 1'b0;
        hsel       = 1'b0;
        haddr      = 8'h00;
        htrans     = 2'b00;
        hwrite     = 1'b0;
        hwdata     = 32'h0;
        fuse       = 8'h00;
        unlock     = 1'b0;
        deep_sleep = 1'b0;
        below      = 1'b0;
        cyc(2);
        t_fuse_regs();
        t_thresholds();
        t_edges();
        t_modes();
        results();
    end

endmodule : tb_brownout_supply_monitor_regs

`default_nettype wire
